// File: verilog/eewc_pkg.sv
// package: constants and register map of the extended event wakeup controller
package eewc_pkg;

  // ***********************************************************************
  // line counts and widths
  // ***********************************************************************
  localparam int NCFG = 20;
  localparam int NPIN_CFG = 16;
  localparam int NDIR = 8;
  localparam int NLINE = NCFG + NDIR;
  localparam int NPORT = 12;
  localparam int PINS_PER_PORT = 16;
  localparam int NSEL = 16;
  localparam int SEL_W = 4;
  localparam int SEL_STRIDE = 8;
  localparam int SEL_PER_REG = 4;
  localparam int NSEL_REG = 4;
  localparam int NMASK = 8;
  localparam int NCORE = 2;
  localparam int AW = 12;
  localparam int DW = 32;

  // ***********************************************************************
  // register offsets (byte addresses)
  // ***********************************************************************
  localparam logic [AW-1:0] OFF_RISE = 12'h000;
  localparam logic [AW-1:0] OFF_FALL = 12'h004;
  localparam logic [AW-1:0] OFF_SWTRIG = 12'h008;
  localparam logic [AW-1:0] OFF_PEND = 12'h00c;
  localparam logic [AW-1:0] OFF_MASK0 = 12'h010;
  localparam logic [AW-1:0] OFF_CFG_SEC = 12'h030;
  localparam logic [AW-1:0] OFF_DIR_SEC = 12'h034;
  localparam logic [AW-1:0] OFF_MUX_SEC = 12'h038;
  localparam logic [AW-1:0] OFF_SEL0 = 12'h040;
  localparam logic [AW-1:0] OFF_DIR_STAT = 12'h050;
  localparam logic [AW-1:0] OFF_LINE_STAT = 12'h054;
  localparam logic [AW-1:0] REG_STEP = 12'h004;

  // mask register index order inside the mask bank
  localparam int MASK_FIRST_DIR = 4;
  localparam int MASK_PER_CORE = 2;
  localparam int MASK_EVT = 1;

  // ***********************************************************************
  // field masks and reset values
  // ***********************************************************************
  localparam logic [DW-1:0] CFG_BITS = 32'h000f_ffff;
  localparam logic [DW-1:0] DIR_BITS = 32'h0000_00ff;
  localparam logic [DW-1:0] MUX_BITS = 32'h0000_ffff;
  localparam logic [DW-1:0] SEL_FIELD = 32'h0000_000f;
  localparam logic [DW-1:0] ALL_BITS = 32'hffff_ffff;
  localparam logic [DW-1:0] RST_ZERO = 32'h0000_0000;

  // pprot bit that marks a non-secure access
  localparam int PROT_NS_BIT = 1;

endpackage

// File: verilog/eewc_edge_if.sv
// interface: synchronised line levels and edge pulses
`timescale 1ns/1ps
interface eewc_edge_if;
  logic [eewc_pkg::NLINE-1:0] level;
  logic [eewc_pkg::NLINE-1:0] rise;
  logic [eewc_pkg::NLINE-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// File: verilog/eewc_line_sync.sv
// module: two-stage synchroniser and edge detector for all lines
`timescale 1ns/1ps
module eewc_line_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw asynchronous lines
  input wire logic [eewc_pkg::NLINE-1:0] raw_in,
  // synchronised result
  eewc_edge_if.src edge_o
);

  logic [eewc_pkg::NLINE-1:0] meta_reg;
  logic [eewc_pkg::NLINE-1:0] sync_reg;
  logic [eewc_pkg::NLINE-1:0] prev_reg;

  // meta_reg is read only by sync_reg
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign edge_o.level = sync_reg;
  assign edge_o.rise = sync_reg & ~prev_reg;
  assign edge_o.fall = ~sync_reg & prev_reg;

endmodule // eewc_line_sync

// File: verilog/eewc_top.sv
// module: extended event wakeup controller with apb register block
//
// Overview of operation
// - software picks rising, falling or both edges
// - each configurable line keeps readable pending flag
// - software trigger bit acts like hardware edge
// - direct lines trigger on rising edge only
// - direct lines hold no pending bit here
// - direct lines have own interrupt and event masks
// - no software trigger exists for direct lines
// - independent interrupt and event masks per core
// - lines wake first, second or both cores
// - unmasked line wakes a core in stop state
// - sixteen selectors pick pin n from ports
// - selected pin goes to matrix and line
// - pin lines reach outputs for stop wakeup
// - security bits restrict configuration to secure access
// - one security bit per matrix event line
// - all registers reached over the slave bus
// - masking stage feeds wakeup, interrupt, event outputs
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module eewc_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [eewc_pkg::AW-1:0] paddr,
  input wire logic [2:0] pprot,
  input wire logic [eewc_pkg::DW-1:0] pwdata,
  output logic [eewc_pkg::DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // line sources
  input wire logic [eewc_pkg::NPORT*eewc_pkg::PINS_PER_PORT-1:0] port_pins,
  input wire logic [eewc_pkg::NCFG-eewc_pkg::NPIN_CFG-1:0] periph_cfg_in,
  input wire logic [eewc_pkg::NDIR-1:0] direct_in,
  // peripheral trigger matrix
  output logic [eewc_pkg::NSEL-1:0] matrix_trig,
  // first core
  output logic [eewc_pkg::NLINE-1:0] first_core_irq,
  output logic [eewc_pkg::NLINE-1:0] first_core_evt,
  output logic first_core_wake,
  // second core
  output logic [eewc_pkg::NLINE-1:0] second_core_irq,
  output logic [eewc_pkg::NLINE-1:0] second_core_evt,
  output logic second_core_wake
);

  // ***********************************************************************
  // helper functions
  // ***********************************************************************
  // bits a master may change: all when secure, else only unsecured ones
  function automatic logic [eewc_pkg::DW-1:0] allow_bits(
    input logic [eewc_pkg::DW-1:0] sec,
    input logic secure
  );
    allow_bits = secure ? eewc_pkg::ALL_BITS : ~sec;
  endfunction

  function automatic logic [eewc_pkg::DW-1:0] sec_write(
    input logic [eewc_pkg::DW-1:0] old,
    input logic [eewc_pkg::DW-1:0] wdat,
    input logic [eewc_pkg::DW-1:0] allow
  );
    sec_write = (old & ~allow) | (wdat & allow);
  endfunction

  // spread per-selector security bits onto the fields of one select register
  function automatic logic [eewc_pkg::DW-1:0] sel_sec(
    input logic [eewc_pkg::DW-1:0] msec,
    input int r
  );
    logic [eewc_pkg::DW-1:0] s;
    s = eewc_pkg::RST_ZERO;
    for (int k = 0; k < eewc_pkg::SEL_PER_REG; k++) begin
      if (msec[r*eewc_pkg::SEL_PER_REG+k]) begin
        s = s | (eewc_pkg::SEL_FIELD << (k*eewc_pkg::SEL_STRIDE));
      end
    end
    sel_sec = s;
  endfunction

  // ***********************************************************************
  // state
  // ***********************************************************************
  logic [eewc_pkg::DW-1:0] rise_sel_reg;
  logic [eewc_pkg::DW-1:0] fall_sel_reg;
  logic [eewc_pkg::DW-1:0] pend_reg;
  logic [eewc_pkg::DW-1:0] pend_next;
  logic [eewc_pkg::DW-1:0] mask_reg [eewc_pkg::NMASK];
  logic [eewc_pkg::DW-1:0] cfg_sec_reg;
  logic [eewc_pkg::DW-1:0] dir_sec_reg;
  logic [eewc_pkg::DW-1:0] mux_sec_reg;
  logic [eewc_pkg::DW-1:0] sel_reg [eewc_pkg::NSEL_REG];
  logic [eewc_pkg::DW-1:0] rd_next;
  logic rd_hit;
  logic secure_acc;
  logic wr_en;
  logic [eewc_pkg::DW-1:0] cfg_allow;
  logic [eewc_pkg::DW-1:0] dir_allow;
  logic [eewc_pkg::DW-1:0] sw_set;
  logic [eewc_pkg::DW-1:0] pend_clr;
  logic [eewc_pkg::DW-1:0] hw_set;
  logic [eewc_pkg::NSEL-1:0] mux_out;
  logic [eewc_pkg::NLINE-1:0] line_act;
  logic [eewc_pkg::NLINE-1:0] line_trig;
  logic [eewc_pkg::NLINE-1:0] imask [eewc_pkg::NCORE];
  logic [eewc_pkg::NLINE-1:0] emask [eewc_pkg::NCORE];

  eewc_edge_if lines_if ();

  // ***********************************************************************
  // pin selection
  // ***********************************************************************
  // the mux sits ahead of the synchroniser; a select change may give one
  // spurious edge, so software should mask the line while reselecting
  always_comb begin
    for (int n = 0; n < eewc_pkg::NSEL; n++) begin
      logic [eewc_pkg::SEL_W-1:0] s;
      s = sel_reg[n/eewc_pkg::SEL_PER_REG][(n%eewc_pkg::SEL_PER_REG)*eewc_pkg::SEL_STRIDE +:
        eewc_pkg::SEL_W];
      if (int'(s) < eewc_pkg::NPORT) begin
        mux_out[n] = port_pins[int'(s)*eewc_pkg::PINS_PER_PORT + n];
      end else begin
        mux_out[n] = 1'b0;
      end
    end
  end

  eewc_line_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw_in({direct_in, periph_cfg_in, mux_out}),
    .edge_o(lines_if.src)
  );

  // ***********************************************************************
  // apb slave
  // ***********************************************************************
  assign secure_acc = ~pprot[eewc_pkg::PROT_NS_BIT];
  assign wr_en = psel & penable & pready & pwrite;
  assign cfg_allow = allow_bits(cfg_sec_reg, secure_acc) & eewc_pkg::CFG_BITS;
  assign dir_allow = allow_bits(dir_sec_reg, secure_acc) & eewc_pkg::DIR_BITS;

  // zero wait state: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= eewc_pkg::RST_ZERO;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
      if (psel && !penable) begin
        prdata <= pwrite ? eewc_pkg::RST_ZERO : rd_next;
      end
    end
  end

  // secured bits read as zero to a non-secure master
  always_comb begin
    rd_hit = 1'b1;
    rd_next = eewc_pkg::RST_ZERO;
    if (paddr == eewc_pkg::OFF_RISE) begin
      rd_next = rise_sel_reg & cfg_allow;
    end else if (paddr == eewc_pkg::OFF_FALL) begin
      rd_next = fall_sel_reg & cfg_allow;
    end else if (paddr == eewc_pkg::OFF_SWTRIG) begin
      rd_next = eewc_pkg::RST_ZERO;
    end else if (paddr == eewc_pkg::OFF_PEND) begin
      rd_next = pend_reg & cfg_allow;
    end else if (paddr == eewc_pkg::OFF_CFG_SEC) begin
      rd_next = cfg_sec_reg;
    end else if (paddr == eewc_pkg::OFF_DIR_SEC) begin
      rd_next = dir_sec_reg;
    end else if (paddr == eewc_pkg::OFF_MUX_SEC) begin
      rd_next = mux_sec_reg;
    end else if (paddr == eewc_pkg::OFF_DIR_STAT) begin
      rd_next = {{(eewc_pkg::DW-eewc_pkg::NDIR){1'b0}},
        lines_if.level[eewc_pkg::NLINE-1:eewc_pkg::NCFG]} & dir_allow;
    end else if (paddr == eewc_pkg::OFF_LINE_STAT) begin
      rd_next = {{(eewc_pkg::DW-eewc_pkg::NCFG){1'b0}},
        lines_if.level[eewc_pkg::NCFG-1:0]} & cfg_allow;
    end else begin
      rd_hit = 1'b0;
      for (int i = 0; i < eewc_pkg::NMASK; i++) begin
        if (paddr == eewc_pkg::OFF_MASK0 + eewc_pkg::AW'(i) * eewc_pkg::REG_STEP) begin
          rd_hit = 1'b1;
          rd_next = mask_reg[i] & (i < eewc_pkg::MASK_FIRST_DIR ? cfg_allow : dir_allow);
        end
      end
      for (int r = 0; r < eewc_pkg::NSEL_REG; r++) begin
        if (paddr == eewc_pkg::OFF_SEL0 + eewc_pkg::AW'(r) * eewc_pkg::REG_STEP) begin
          rd_hit = 1'b1;
          rd_next = sel_reg[r] & ~sel_sec(mux_sec_reg, r) | sel_reg[r] &
            {eewc_pkg::DW{secure_acc}};
        end
      end
    end
  end

  // ***********************************************************************
  // security enables: secure masters only
  // ***********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_sec_reg <= eewc_pkg::RST_ZERO;
      dir_sec_reg <= eewc_pkg::RST_ZERO;
      mux_sec_reg <= eewc_pkg::RST_ZERO;
    end else if (wr_en && secure_acc) begin
      if (paddr == eewc_pkg::OFF_CFG_SEC) begin
        cfg_sec_reg <= pwdata & eewc_pkg::CFG_BITS;
      end else if (paddr == eewc_pkg::OFF_DIR_SEC) begin
        dir_sec_reg <= pwdata & eewc_pkg::DIR_BITS;
      end else if (paddr == eewc_pkg::OFF_MUX_SEC) begin
        mux_sec_reg <= pwdata & eewc_pkg::MUX_BITS;
      end
    end
  end

  // ***********************************************************************
  // edge selection
  // ***********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_sel_reg <= eewc_pkg::RST_ZERO;
      fall_sel_reg <= eewc_pkg::RST_ZERO;
    end else if (wr_en) begin
      if (paddr == eewc_pkg::OFF_RISE) begin
        rise_sel_reg <= sec_write(rise_sel_reg, pwdata, cfg_allow);
      end else if (paddr == eewc_pkg::OFF_FALL) begin
        fall_sel_reg <= sec_write(fall_sel_reg, pwdata, cfg_allow);
      end
    end
  end

  // ***********************************************************************
  // pending flags of configurable lines
  // ***********************************************************************
  // only cfg_allow bits exist, so direct lines cannot be soft-triggered
  assign sw_set = (wr_en && paddr == eewc_pkg::OFF_SWTRIG) ? pwdata & cfg_allow :
    eewc_pkg::RST_ZERO;
  assign pend_clr = (wr_en && paddr == eewc_pkg::OFF_PEND) ? pwdata & cfg_allow :
    eewc_pkg::RST_ZERO;
  assign hw_set = {{(eewc_pkg::DW-eewc_pkg::NCFG){1'b0}},
    lines_if.rise[eewc_pkg::NCFG-1:0] & rise_sel_reg[eewc_pkg::NCFG-1:0] |
    lines_if.fall[eewc_pkg::NCFG-1:0] & fall_sel_reg[eewc_pkg::NCFG-1:0]};
  // a new edge in the clearing cycle wins over the clear
  assign pend_next = (pend_reg & ~pend_clr) | hw_set | sw_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= eewc_pkg::RST_ZERO;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // ***********************************************************************
  // per-core masks and pin selectors
  // ***********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < eewc_pkg::NMASK; i++) begin
        mask_reg[i] <= eewc_pkg::RST_ZERO;
      end
    end else if (wr_en) begin
      for (int i = 0; i < eewc_pkg::NMASK; i++) begin
        if (paddr == eewc_pkg::OFF_MASK0 + eewc_pkg::AW'(i) * eewc_pkg::REG_STEP) begin
          mask_reg[i] <= sec_write(mask_reg[i], pwdata,
            i < eewc_pkg::MASK_FIRST_DIR ? cfg_allow : dir_allow);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int r = 0; r < eewc_pkg::NSEL_REG; r++) begin
        sel_reg[r] <= eewc_pkg::RST_ZERO;
      end
    end else if (wr_en) begin
      for (int r = 0; r < eewc_pkg::NSEL_REG; r++) begin
        if (paddr == eewc_pkg::OFF_SEL0 + eewc_pkg::AW'(r) * eewc_pkg::REG_STEP) begin
          sel_reg[r] <= sec_write(sel_reg[r], pwdata,
            allow_bits(sel_sec(mux_sec_reg, r), secure_acc) & sel_sec(
            eewc_pkg::MUX_BITS, r));
        end
      end
    end
  end

  // ***********************************************************************
  // masking stage
  // ***********************************************************************
  // direct lines: active while the source holds its level, cleared there
  assign line_act = {lines_if.level[eewc_pkg::NLINE-1:eewc_pkg::NCFG],
    pend_reg[eewc_pkg::NCFG-1:0]};
  assign line_trig = {lines_if.rise[eewc_pkg::NLINE-1:eewc_pkg::NCFG],
    hw_set[eewc_pkg::NCFG-1:0] | sw_set[eewc_pkg::NCFG-1:0]};

  always_comb begin
    for (int c = 0; c < eewc_pkg::NCORE; c++) begin
      imask[c] = {mask_reg[eewc_pkg::MASK_FIRST_DIR + c*eewc_pkg::MASK_PER_CORE]
        [eewc_pkg::NDIR-1:0], mask_reg[c*eewc_pkg::MASK_PER_CORE][eewc_pkg::NCFG-1:0]};
      emask[c] = {mask_reg[eewc_pkg::MASK_FIRST_DIR + c*eewc_pkg::MASK_PER_CORE +
        eewc_pkg::MASK_EVT][eewc_pkg::NDIR-1:0],
        mask_reg[c*eewc_pkg::MASK_PER_CORE + eewc_pkg::MASK_EVT][eewc_pkg::NCFG-1:0]};
    end
  end

  // wake is raised whether or not the core sits in its stop state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_core_irq <= '0;
      first_core_evt <= '0;
      first_core_wake <= 1'b0;
      second_core_irq <= '0;
      second_core_evt <= '0;
      second_core_wake <= 1'b0;
    end else begin
      first_core_irq <= line_act & imask[0];
      first_core_evt <= line_trig & emask[0];
      first_core_wake <= |(line_act & (imask[0] | emask[0]));
      second_core_irq <= line_act & imask[1];
      second_core_evt <= line_trig & emask[1];
      second_core_wake <= |(line_act & (imask[1] | emask[1]));
    end
  end

  // ***********************************************************************
  // matrix trigger
  // ***********************************************************************
  // limitation: the pin path runs on pclk, so stop wakeup needs pclk alive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      matrix_trig <= '0;
    end else begin
      matrix_trig <= lines_if.level[eewc_pkg::NSEL-1:0];
    end
  end

endmodule // eewc_top

// File: verification/eewc_periph_model.sv
// partner model: peripheral status flags that drive the direct lines
`timescale 1ns/1ps
module eewc_periph_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // peripheral events and software clears
  input wire logic [eewc_pkg::NDIR-1:0] raise,
  input wire logic [eewc_pkg::NDIR-1:0] clear,
  // status flags towards the controller
  output logic [eewc_pkg::NDIR-1:0] status
);
  // the flag stays up until the owner clears it in the peripheral
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      status <= (status | raise) & ~clear;
    end
  end
endmodule // eewc_periph_model

// File: verification/eewc_chk.sv
// checker: concurrent assertions on the controller's top-level ports
`timescale 1ns/1ps
module eewc_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [eewc_pkg::DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // lines
  input wire logic [eewc_pkg::NPORT*eewc_pkg::PINS_PER_PORT-1:0] port_pins,
  input wire logic [eewc_pkg::NDIR-1:0] direct_in,
  input wire logic [eewc_pkg::NSEL-1:0] matrix_trig,
  // cores
  input wire logic [eewc_pkg::NLINE-1:0] first_core_irq,
  input wire logic [eewc_pkg::NLINE-1:0] first_core_evt,
  input wire logic first_core_wake,
  input wire logic [eewc_pkg::NLINE-1:0] second_core_irq,
  input wire logic [eewc_pkg::NLINE-1:0] second_core_evt,
  input wire logic second_core_wake
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no answer in access cycle");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready held too long");
  property p_ready_acc; pready |-> psel && penable; endproperty
  a_ready_acc: assert property (p_ready_acc) else $error("ready outside access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  // a write setup also reloads prdata (to zero), so any setup may move it
  property p_rdata; !$stable(prdata) |-> $past(psel && !penable); endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved without read");
  property p_evt1; (first_core_evt & $past(first_core_evt)) == '0; endproperty
  a_evt1: assert property (p_evt1) else $error("first core event not a pulse");
  property p_evt2; (second_core_evt & $past(second_core_evt)) == '0; endproperty
  a_evt2: assert property (p_evt2) else $error("second core event not a pulse");
  // direct requests must vanish once the source flag is gone
  property p_dir_quiet;
    (direct_in == '0) [*8] |-> first_core_irq[27:20] == '0 && second_core_irq[27:20] == '0;
  endproperty
  a_dir_quiet: assert property (p_dir_quiet) else $error("direct irq without source");
  property p_pin_quiet; (port_pins == '0) [*4] |-> matrix_trig == '0; endproperty
  a_pin_quiet: assert property (p_pin_quiet) else $error("matrix trigger without pin");
  property p_wake1; (|first_core_irq) |-> first_core_wake; endproperty
  a_wake1: assert property (p_wake1) else $error("first core irq without wake");
  property p_wake2; (|second_core_irq) |-> second_core_wake; endproperty
  a_wake2: assert property (p_wake2) else $error("second core irq without wake");
  c_err: cover property (pready && pslverr);
  c_evt: cover property (|first_core_evt);
  c_wake2: cover property (second_core_wake);
endmodule // eewc_chk
bind eewc_top eewc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_pins(port_pins), .direct_in(direct_in), .matrix_trig(matrix_trig),
  .first_core_irq(first_core_irq), .first_core_evt(first_core_evt),
  .first_core_wake(first_core_wake), .second_core_irq(second_core_irq),
  .second_core_evt(second_core_evt), .second_core_wake(second_core_wake));

// File: verification/test_extended_event_wakeup_controller.sv
// testbench: register sequences and line stimulus for the wakeup controller
`timescale 1ns/1ps
module test_extended_event_wakeup_controller;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr, wake1, wake2;
  logic [eewc_pkg::AW-1:0] paddr = '0;
  logic [2:0] pprot = 3'h0;
  logic [eewc_pkg::DW-1:0] pwdata = '0, prdata, rdat;
  logic [eewc_pkg::NPORT*eewc_pkg::PINS_PER_PORT-1:0] port_pins = '0;
  logic [eewc_pkg::NDIR-1:0] direct_in, raise = '0, clear = '0;
  logic [eewc_pkg::NSEL-1:0] mtrig;
  logic [eewc_pkg::NLINE-1:0] irq1, evt1, irq2, evt2, seen1;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  eewc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pprot(pprot), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_pins(port_pins), .periph_cfg_in(4'h0),
    .direct_in(direct_in), .matrix_trig(mtrig), .first_core_irq(irq1),
    .first_core_evt(evt1), .first_core_wake(wake1), .second_core_irq(irq2),
    .second_core_evt(evt2), .second_core_wake(wake2));
  eewc_periph_model u_periph (.pclk(pclk), .presetn(presetn), .raise(raise), .clear(clear),
    .status(direct_in));

  always #2 pclk = ~pclk;
  // ******************************************************************
  // run control
  // ******************************************************************
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // ******************************************************************
  // apb master and line drivers, entered just after a rising edge
  // ******************************************************************
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(nm, rdat, exp);
  endtask
  // evt pulses last one cycle, so evt1 pulses are collected into seen1
  task tick(input int n);
    repeat (n) begin
      @(posedge pclk);
      seen1 = seen1 | evt1;
    end
  endtask
  task pin(input int i, input logic v);
    port_pins[i] <= v;
    tick(6);
  endtask
  task periph(input logic [7:0] r, input logic [7:0] c);
    raise <= r;
    clear <= c;
    @(posedge pclk);
    raise <= 8'h00;
    clear <= 8'h00;
    tick(6);
  endtask

  initial begin
    seen1 = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk("rise", eewc_pkg::OFF_RISE, 32'h0);
    rdchk("pend", eewc_pkg::OFF_PEND, 32'h0);
    xfer(1'b0, 12'hffc, 32'h0);
    chk("slverr", {31'h0, rerr}, 32'h1);
    $display("test reset done");
    wr(eewc_pkg::OFF_SEL0, 32'h0000_0002);
    wr(eewc_pkg::OFF_RISE, 32'h0000_0001);
    wr(eewc_pkg::OFF_MASK0, 32'h0000_0001);
    pin(0, 1'b1);
    chk("mtrig", {16'h0, mtrig}, 32'h0);
    rdchk("pend", eewc_pkg::OFF_PEND, 32'h0);
    pin(32, 1'b1);
    chk("mtrig", {16'h0, mtrig}, 32'h1);
    rdchk("pend", eewc_pkg::OFF_PEND, 32'h1);
    chk("irq1", {4'h0, irq1}, 32'h1);
    chk("irq2", {4'h0, irq2}, 32'h0);
    chk("wake", {30'h0, wake2, wake1}, 32'h1);
    wr(eewc_pkg::OFF_PEND, 32'h0000_0001);
    tick(3);
    rdchk("pend", eewc_pkg::OFF_PEND, 32'h0);
    chk("irq1", {4'h0, irq1}, 32'h0);
    $display("test selector done");
    wr(eewc_pkg::OFF_FALL, 32'h0000_0002);
    wr(eewc_pkg::OFF_MASK0 + 12'h004, 32'h0000_0002);
    pin(1, 1'b1);
    rdchk("pend", eewc_pkg::OFF_PEND, 32'h0);
    seen1 = '0;
    pin(1, 1'b0);
    rdchk("pend", eewc_pkg::OFF_PEND, 32'h2);
    chk("evt1", {4'h0, seen1}, 32'h2);
    wr(eewc_pkg::OFF_PEND, 32'h0000_0002);
    wr(eewc_pkg::OFF_RISE, 32'h0000_0003);
    pin(1, 1'b1);
    rdchk("pend", eewc_pkg::OFF_PEND, 32'h2);
    wr(eewc_pkg::OFF_PEND, 32'h0000_0002);
    $display("test edges done");
    wr(eewc_pkg::OFF_MASK0 + 12'h008, 32'h0002_0000);
    wr(eewc_pkg::OFF_MASK0 + 12'h00c, 32'h0002_0000);
    wr(eewc_pkg::OFF_SWTRIG, 32'h0002_0000);
    chk("evt2", {4'h0, evt2}, 32'h0002_0000);
    tick(3);
    rdchk("swtrig", eewc_pkg::OFF_SWTRIG, 32'h0);
    rdchk("pend", eewc_pkg::OFF_PEND, 32'h0002_0000);
    chk("wake", {30'h0, wake2, wake1}, 32'h2);
    wr(eewc_pkg::OFF_PEND, 32'h0000_0000);
    rdchk("pend", eewc_pkg::OFF_PEND, 32'h0002_0000);
    wr(eewc_pkg::OFF_PEND, 32'h0002_0000);
    tick(3);
    chk("wake", {30'h0, wake2, wake1}, 32'h0);
    $display("test software trigger done");
    wr(eewc_pkg::OFF_MASK0 + 12'h018, 32'h0000_0001);
    wr(eewc_pkg::OFF_SWTRIG, 32'h0010_0000);
    tick(3);
    chk("irq2", {4'h0, irq2}, 32'h0);
    periph(8'h01, 8'h00);
    chk("irq2", {4'h0, irq2}, 32'h0010_0000);
    chk("irq1", {4'h0, irq1}, 32'h0);
    rdchk("pend", eewc_pkg::OFF_PEND, 32'h0);
    periph(8'h00, 8'h01);
    chk("irq2", {4'h0, irq2}, 32'h0);
    wr(eewc_pkg::OFF_MASK0 + 12'h014, 32'h0000_0002);
    seen1 = '0;
    periph(8'h02, 8'h00);
    chk("evt1", {4'h0, seen1}, 32'h0020_0000);
    chk("irq1", {4'h0, irq1}, 32'h0);
    seen1 = '0;
    periph(8'h00, 8'h02);
    chk("evt1", {4'h0, seen1}, 32'h0);
    $display("test direct lines done");
    pprot <= 3'h2;
    wr(eewc_pkg::OFF_CFG_SEC, 32'h0000_0004);
    rdchk("cfgsec", eewc_pkg::OFF_CFG_SEC, 32'h0);
    pprot <= 3'h0;
    wr(eewc_pkg::OFF_CFG_SEC, 32'h0000_0004);
    wr(eewc_pkg::OFF_MUX_SEC, 32'h0000_0001);
    pprot <= 3'h2;
    wr(eewc_pkg::OFF_RISE, 32'h0000_0007);
    wr(eewc_pkg::OFF_SEL0, 32'h0000_0000);
    rdchk("sel_ns", eewc_pkg::OFF_SEL0, 32'h0);
    pprot <= 3'h0;
    rdchk("rise", eewc_pkg::OFF_RISE, 32'h3);
    rdchk("sel", eewc_pkg::OFF_SEL0, 32'h2);
    $display("test security done");
    summarize();
  end
endmodule // test_extended_event_wakeup_controller
